// [verilog/pmc_pkg.sv]
package pmc_pkg;
  localparam int PMC_NUM_CTR = 8;
  localparam int PMC_CTR_W = 48;
  localparam int PMC_SEG_W = 16;
  localparam int PMC_NUM_SEG = 3;
  localparam int PMC_AMT_W = 7;
  localparam int PMC_RD_LSB = 32;
  localparam int PMC_SREG_W = 64;
  localparam logic [PMC_CTR_W-1:0] PMC_CNT_RST = 48'h0000_0000_0000;
  localparam logic [PMC_CTR_W-1:0] PMC_INJECT = 48'h0040_0040_0000;
  localparam logic [2:0] PMC_PTR_CTR_RST = 3'h0;
  localparam logic [1:0] PMC_PTR_SEG_RST = 2'h0;
  localparam logic [1:0] PMC_SEG_LAST = 2'h2;
  localparam logic [2:0] PMC_CTR_LAST = 3'h7;
  // Opcode class bounds, seven-bit opcode space
  localparam logic [6:0] PMC_OPC_017 = 7'h0f;
  localparam logic [6:0] PMC_OPC_077 = 7'h3f;
  localparam logic [6:0] PMC_OPC_137 = 7'h5f;
  localparam logic [6:0] PMC_OPC_157 = 7'h6f;
  localparam logic [6:0] PMC_OPC_173 = 7'h7b;
  localparam logic [6:0] PMC_OPC_174 = 7'h7c;
  localparam logic [6:0] PMC_OPC_175 = 7'h7d;

  typedef enum logic [1:0] {PMC_GRP_ISSUE, PMC_GRP_HOLD, PMC_GRP_MEM, PMC_GRP_OPC} pmc_group_t;

  // Monitor instructions, one-cycle pulses from the issue logic
  typedef struct packed {
    logic sel;
    logic [1:0] grp;
    logic rd;
    logic inj;
    logic mclr;
    logic minc;
  } pmc_cmd_t;

  // A functional unit operation: scalar counts one, vector counts the length
  typedef struct packed {
    logic valid;
    logic vec;
  } pmc_op_t;

  typedef struct packed {
    logic issue;
    logic [6:0] opcode;
    logic k_zero;
    logic hold_any;
    logic [7:0] hold_cause;
    logic fetch;
    logic cache_hit;
    pmc_op_t fadd;
    pmc_op_t fmul;
    pmc_op_t frecip;
    logic ms_ref;
    logic ms_wr;
    logic mv_ref;
    logic mv_wr;
    logic mb_ref;
    logic mb_wr;
    logic mem_conflict;
    logic vint;
    logic vfp;
    logic [PMC_AMT_W-1:0] vl;
    logic [PMC_AMT_W-1:0] bt_cnt;
  } pmc_ev_t;

  typedef struct packed {
    logic valid;
    logic [PMC_SREG_W-1:0] data;
  } pmc_rd_t;
endpackage

// [verilog/pmc_monitor.sv]
`timescale 1ns/10ps
// How it works
// - Eight counters whose events depend on which of four groups is active.
// - Events advance counters only while the processor runs outside monitor mode; maintenance increment and inject act in it too.
// - Entering monitor mode stops event counting on every counter until the processor leaves it.
// - The group-select instruction carries the group number, which is latched.
// - Group 0 counts issues, hold cycles, fetches, float add/multiply/reciprocal, memory references, cache hits.
// - Group 1 counts hold-issue cycles per cause: A, S, V, B/T, vector units, shared, ports, miscellaneous.
// - Group 2 counts fetches, hits, scalar writes, B/T refs, scalar refs, CPU writes, CPU refs, conflicts.
// - Group 3 counts issued opcode classes on counters 0 to 5 and vector integer/float ops on 6 and 7.
// - Increments are one per scalar event, vector length per vector op, transfer count per block transfer.
// - Select and read instructions for users, plus inject, clear and increment for maintenance.
// - Group select also clears all counters and the read pointer.
// - Each counter is 48 bits in three 16-bit segments chosen by a read pointer.
// - A read returns the pointed segment in result bits 32 to 47 and advances the pointer.
// - The pointer clears on entering or leaving monitor mode, group select and maintenance clear.
module pmc_monitor
  import pmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic monitor_mode,
  input wire pmc_cmd_t cmd,
  input wire pmc_ev_t ev,
  output pmc_rd_t rd_out,
  output pmc_group_t group
);

  logic [PMC_CTR_W-1:0] cnt [PMC_NUM_CTR];
  logic [PMC_CTR_W-1:0] next_cnt [PMC_NUM_CTR];
  logic [PMC_CTR_W-1:0] inc [PMC_NUM_CTR];
  logic [2:0] ptr_ctr;
  logic [2:0] next_ptr_ctr;
  logic [1:0] ptr_seg;
  logic [1:0] next_ptr_seg;
  logic mode_q;
  logic mode_edge;
  logic count_en;
  pmc_group_t next_group;
  pmc_rd_t next_rd_out;
  logic [PMC_SEG_W-1:0] seg_val;
  logic [PMC_CTR_W-1:0] mem_ref_amt;
  logic [PMC_CTR_W-1:0] mem_wr_amt;

  // Scalar op adds one, vector op adds its length
  function automatic logic [PMC_CTR_W-1:0] op_amt(input pmc_op_t op, input logic [PMC_AMT_W-1:0] vl);
    logic [PMC_CTR_W-1:0] r;
    r = '0;
    if (op.valid) begin
      r = op.vec ? PMC_CTR_W'(vl) : PMC_CTR_W'(1'b1);
    end
    return r;
  endfunction

  // Counting stops the same cycle monitor mode rises, no lag through a flop
  // gate by mode
  assign count_en = !monitor_mode;
  assign mode_edge = monitor_mode ^ mode_q;

  // Memory totals mix scalar, vector and block references in one cycle
  // per-class amounts
  always_comb begin
    mem_ref_amt = PMC_CTR_W'(ev.ms_ref)
                + (ev.mv_ref ? PMC_CTR_W'(ev.vl) : '0)
                + (ev.mb_ref ? PMC_CTR_W'(ev.bt_cnt) : '0);
    mem_wr_amt = PMC_CTR_W'(ev.ms_wr)
               + (ev.mv_wr ? PMC_CTR_W'(ev.vl) : '0)
               + (ev.mb_wr ? PMC_CTR_W'(ev.bt_cnt) : '0);
  end

  // Per-counter increment for the active group
  // group steers events
  always_comb begin
    for (int i = 0; i < PMC_NUM_CTR; i++) begin
      inc[i] = '0;
    end
    unique case (group)
      PMC_GRP_ISSUE: begin
        inc[0] = PMC_CTR_W'(ev.issue);
        inc[1] = PMC_CTR_W'(ev.hold_any);
        inc[2] = PMC_CTR_W'(ev.fetch);
        inc[3] = op_amt(ev.fadd, ev.vl);
        inc[4] = op_amt(ev.fmul, ev.vl);
        inc[5] = op_amt(ev.frecip, ev.vl);
        inc[6] = mem_ref_amt;
        inc[7] = PMC_CTR_W'(ev.cache_hit);
      end
      PMC_GRP_HOLD: begin
        for (int i = 0; i < PMC_NUM_CTR; i++) begin
          inc[i] = PMC_CTR_W'(ev.hold_cause[i]);
        end
      end
      PMC_GRP_MEM: begin
        inc[0] = PMC_CTR_W'(ev.fetch);
        inc[1] = PMC_CTR_W'(ev.cache_hit);
        inc[2] = PMC_CTR_W'(ev.ms_wr);
        inc[3] = ev.mb_ref ? PMC_CTR_W'(ev.bt_cnt) : '0;
        inc[4] = PMC_CTR_W'(ev.ms_ref);
        inc[5] = mem_wr_amt;
        inc[6] = mem_ref_amt;
        inc[7] = PMC_CTR_W'(ev.mem_conflict);
      end
      PMC_GRP_OPC: begin
        if (ev.issue) begin
          if (ev.opcode <= PMC_OPC_017) begin
            inc[0] = PMC_CTR_W'(1'b1);
          end else if (ev.opcode <= PMC_OPC_077) begin
            inc[1] = PMC_CTR_W'(1'b1);
          end else if (ev.opcode <= PMC_OPC_137) begin
            inc[2] = PMC_CTR_W'(1'b1);
          end else if (ev.opcode <= PMC_OPC_157 || (ev.opcode == PMC_OPC_174 && !ev.k_zero)) begin
            inc[3] = PMC_CTR_W'(1'b1);
          end else if (ev.opcode <= PMC_OPC_173 || ev.opcode == PMC_OPC_174) begin
            inc[4] = PMC_CTR_W'(1'b1);
          end else if (ev.opcode > PMC_OPC_175) begin
            inc[5] = PMC_CTR_W'(1'b1);
          end
        end
        inc[6] = ev.vint ? PMC_CTR_W'(ev.vl) : '0;
        inc[7] = ev.vfp ? PMC_CTR_W'(ev.vl) : '0;
      end
    endcase
  end

  // Counter next values; maintenance ops act in monitor mode too
  // user and maintenance ops
  always_comb begin
    for (int i = 0; i < PMC_NUM_CTR; i++) begin
      next_cnt[i] = cnt[i];
      if (cmd.sel) begin
        next_cnt[i] = PMC_CNT_RST;
      end else begin
        if (count_en) begin
          next_cnt[i] = next_cnt[i] + inc[i];
        end
        if (cmd.minc && ptr_ctr == 3'(i)) begin
          next_cnt[i] = next_cnt[i] + PMC_CTR_W'(1'b1);
        end
        if (cmd.inj && ptr_ctr == 3'(i)) begin
          next_cnt[i] = next_cnt[i] + PMC_INJECT;
        end
      end
    end
  end

  // Pointed segment, 48-bit counter seen as three 16-bit slices
  // segment select
  always_comb begin
    unique case (ptr_seg)
      2'h0: seg_val = cnt[ptr_ctr][15:0];
      2'h1: seg_val = cnt[ptr_ctr][31:16];
      default: seg_val = cnt[ptr_ctr][47:32];
    endcase
  end

  // Pointer, group and read result; a clear beats any advance in the same cycle
  always_comb begin
    next_ptr_ctr = ptr_ctr;
    next_ptr_seg = ptr_seg;
    next_group = group;
    next_rd_out.valid = cmd.rd;
    next_rd_out.data = rd_out.data;
    if (cmd.sel) begin
      next_group = pmc_group_t'(cmd.grp);
    end
    if (cmd.rd) begin
      next_rd_out.data = {PMC_SEG_W'(0), seg_val, PMC_RD_LSB'(0)};
    end
    if (cmd.sel || cmd.mclr || mode_edge) begin
      next_ptr_ctr = PMC_PTR_CTR_RST;
      next_ptr_seg = PMC_PTR_SEG_RST;
    end else if (cmd.inj) begin
      next_ptr_ctr = ptr_ctr + 3'h1;
      next_ptr_seg = PMC_PTR_SEG_RST;
    end else if (cmd.rd) begin
      if (ptr_seg == PMC_SEG_LAST) begin
        next_ptr_seg = PMC_PTR_SEG_RST;
        next_ptr_ctr = ptr_ctr + 3'h1;
      end else begin
        next_ptr_seg = ptr_seg + 2'h1;
      end
    end
  end

  // Registers only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < PMC_NUM_CTR; i++) begin
        cnt[i] <= PMC_CNT_RST;
      end
      ptr_ctr <= PMC_PTR_CTR_RST;
      ptr_seg <= PMC_PTR_SEG_RST;
      group <= PMC_GRP_ISSUE;
      mode_q <= 1'b0;
      rd_out <= '0;
    end else begin
      cnt <= next_cnt;
      ptr_ctr <= next_ptr_ctr;
      ptr_seg <= next_ptr_seg;
      group <= next_group;
      mode_q <= monitor_mode;
      rd_out <= next_rd_out;
    end
  end

  // Checks
  logic quiet;
  assign quiet = !cmd.sel && !cmd.minc && !cmd.inj;

  a_sel_clears_all: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd.sel |=> cnt[0] == '0 && cnt[7] == '0 && ptr_ctr == '0 && ptr_seg == '0)
    else $error("select did not clear counters and pointer");

  a_group_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd.sel |=> group == pmc_group_t'($past(cmd.grp)))
    else $error("group not latched from select");

  a_monitor_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (monitor_mode && quiet)[*2] |=> cnt[2] == $past(cnt[2], 2))
    else $error("counter moved in monitor mode");

  a_issue_count: assert property (@(posedge ref_clk) disable iff (!nrst)
    group == PMC_GRP_ISSUE && !monitor_mode && quiet
      |=> cnt[0] == $past(cnt[0]) + PMC_CTR_W'($past(ev.issue)))
    else $error("issue counter wrong");

  a_hold_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    group == PMC_GRP_HOLD && !monitor_mode && quiet
      |=> cnt[7] == $past(cnt[7]) + PMC_CTR_W'($past(ev.hold_cause[7])))
    else $error("hold cause counter wrong");

  a_bt_amount: assert property (@(posedge ref_clk) disable iff (!nrst)
    group == PMC_GRP_MEM && !monitor_mode && quiet && ev.mb_ref
      |=> cnt[3] == $past(cnt[3]) + PMC_CTR_W'($past(ev.bt_cnt)))
    else $error("block transfer amount wrong");

  a_opc_class: assert property (@(posedge ref_clk) disable iff (!nrst)
    group == PMC_GRP_OPC && !monitor_mode && quiet && ev.issue && ev.opcode > PMC_OPC_175
      |=> cnt[5] == $past(cnt[5]) + PMC_CTR_W'(1'b1))
    else $error("opcode class counter wrong");

  a_mem_sum: assert property (@(posedge ref_clk) disable iff (!nrst)
    group == PMC_GRP_MEM && !monitor_mode && quiet && ev.ms_ref && ev.mv_ref
      |=> cnt[6] == $past(cnt[6]) + PMC_CTR_W'(1'b1) + PMC_CTR_W'($past(ev.vl))
        + ($past(ev.mb_ref) ? PMC_CTR_W'($past(ev.bt_cnt)) : PMC_CNT_RST))
    else $error("simultaneous references lost");

  a_rd_place: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd.rd |=> rd_out.valid && rd_out.data[47:32] == $past(seg_val) && rd_out.data[31:0] == '0)
    else $error("read segment misplaced");

  a_ptr_wrap: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd.rd && !cmd.sel && !cmd.mclr && !cmd.inj && !mode_edge && ptr_seg == PMC_SEG_LAST
      |=> ptr_seg == '0 && ptr_ctr == $past(ptr_ctr) + 3'h1)
    else $error("pointer did not step to next counter");

  a_mode_ptr_clr: assert property (@(posedge ref_clk) disable iff (!nrst)
    $changed(monitor_mode) |=> ptr_ctr == '0 && ptr_seg == '0)
    else $error("pointer not cleared on mode change");

  // Extra checks on paths the scenarios reach but the checks above leave open
  a_sel_clears_mid: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd.sel |=> cnt[1] == '0 && cnt[2] == '0 && cnt[3] == '0 && cnt[4] == '0 && cnt[5] == '0
      && cnt[6] == '0)
    else $error("select left a middle counter set");

  a_hold_any: assert property (@(posedge ref_clk) disable iff (!nrst)
    group == PMC_GRP_ISSUE && !monitor_mode && quiet
      |=> cnt[1] == $past(cnt[1]) + PMC_CTR_W'($past(ev.hold_any)))
    else $error("hold issue counter wrong");

  a_vec_amount: assert property (@(posedge ref_clk) disable iff (!nrst)
    group == PMC_GRP_ISSUE && !monitor_mode && quiet && ev.fadd.valid && ev.fadd.vec
      |=> cnt[3] == $past(cnt[3]) + PMC_CTR_W'($past(ev.vl)))
    else $error("vector add amount wrong");

  a_opc_low: assert property (@(posedge ref_clk) disable iff (!nrst)
    group == PMC_GRP_OPC && !monitor_mode && quiet && ev.issue && ev.opcode <= PMC_OPC_017
      |=> cnt[0] == $past(cnt[0]) + PMC_CTR_W'(1'b1))
    else $error("lowest opcode class counter wrong");

  a_mode_retain: assert property (@(posedge ref_clk) disable iff (!nrst)
    monitor_mode && quiet |=> cnt[0] == $past(cnt[0]))
    else $error("counter changed while stopped");

  a_rd_advance: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd.rd && !cmd.sel && !cmd.mclr && !cmd.inj && !mode_edge && ptr_seg != PMC_SEG_LAST
      |=> ptr_seg == $past(ptr_seg) + 2'h1 && ptr_ctr == $past(ptr_ctr))
    else $error("pointer did not step to next segment");

  a_rd_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cmd.rd |=> !rd_out.valid)
    else $error("read result flagged without a read");

  a_mclr_ptr: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd.mclr |=> ptr_ctr == '0 && ptr_seg == '0)
    else $error("pointer not cleared by maintenance clear");

  a_inj_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd.inj && !cmd.sel && !cmd.mclr && !mode_edge
      |=> ptr_ctr == $past(ptr_ctr) + 3'h1 && ptr_seg == '0)
    else $error("inject did not move pointer to next counter");

endmodule

// [dv/pmc_cpu_model.sv]
`timescale 1ns/10ps
// Stand-in for the issue logic, memory ports and units; commands and events are pulses, mode is a level
module pmc_cpu_model
  import pmc_pkg::*;
(
  input wire logic ref_clk,
  output pmc_cmd_t cmd,
  output pmc_ev_t ev,
  output logic monitor_mode
);
  // Quiet from time zero so nothing counts before a scenario asks
  initial begin
    cmd = '0;
    ev = '0;
    monitor_mode = 1'b0;
  end
  // group in field: the group number rides with the select pulse
  task automatic send_cmd(input pmc_cmd_t c);
    @(posedge ref_clk);
    #1 cmd = c;
    @(posedge ref_clk);
    #1 cmd = '0;
  endtask
  // One cycle of events; several may be set together
  task automatic send_ev(input pmc_ev_t e);
    @(posedge ref_clk);
    #1 ev = e;
    @(posedge ref_clk);
    #1 ev = '0;
  endtask
  // Mode is a level, changed off the edge
  task automatic set_mode(input logic m);
    @(posedge ref_clk);
    #1 monitor_mode = m;
  endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
// Bench for the event counter monitor
module tb_top
  import pmc_pkg::*;
;
  logic ref_clk;
  logic nrst;
  logic monitor_mode;
  pmc_cmd_t cmd;
  pmc_ev_t ev;
  pmc_rd_t rd_out;
  pmc_group_t group;
  int fails = 0;
  int cmp_count = 0;

  // Clock and instances
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  pmc_monitor i_pmc_monitor(.ref_clk(ref_clk), .nrst(nrst), .monitor_mode(monitor_mode), .cmd(cmd), .ev(ev),
    .rd_out(rd_out), .group(group));
  pmc_cpu_model i_pmc_cpu_model(.ref_clk(ref_clk), .cmd(cmd), .ev(ev), .monitor_mode(monitor_mode));

  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic close_out();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read one segment; valid stands one cycle, so look right after the answer edge
  task automatic read_seg(output logic [15:0] s);
    i_pmc_cpu_model.send_cmd('{rd: 1'b1, default: '0});
    chk({15'h0, rd_out.valid, rd_out.data[63:48], rd_out.data[31:0]}, 64'h0001_0000_0000_0000);
    s = rd_out.data[47:32];
  endtask

  // Walk all 24 segments; the pointer wraps back to counter 0
  task automatic check_all(input logic [47:0] e [8]);
    logic [15:0] s;
    logic [47:0] v;
    for (int c = 0; c < PMC_NUM_CTR; c++) begin
      for (int k = 0; k < PMC_NUM_SEG; k++) begin
        read_seg(s);
        v[k*16 +: 16] = s;
      end
      chk({16'h0, v}, {16'h0, e[c]});
    end
  endtask

  // A read first moves the pointer, so a failed pointer clear shows later
  task automatic select(input logic [1:0] g);
    logic [15:0] s;
    read_seg(s);
    i_pmc_cpu_model.send_cmd('{sel: 1'b1, grp: g, default: '0});
    chk({62'h0, group}, {62'h0, g});
  endtask

  task automatic s_grp0();
    select(2'h0);
    i_pmc_cpu_model.send_ev('{issue: 1'b1, hold_any: 1'b1, fetch: 1'b1, cache_hit: 1'b1, fadd: 2'h3, fmul: 2'h2,
      frecip: 2'h2, ms_ref: 1'b1, mv_ref: 1'b1, mb_ref: 1'b1, vl: 7'h3, bt_cnt: 7'h5, default: '0});
    check_all('{48'h1, 48'h1, 48'h1, 48'h3, 48'h1, 48'h1, 48'h9, 48'h1});
  endtask

  task automatic s_grp1();
    select(2'h1);
    i_pmc_cpu_model.send_ev('{hold_any: 1'b1, hold_cause: 8'hff, default: '0});
    i_pmc_cpu_model.send_ev('{hold_any: 1'b1, hold_cause: 8'h05, default: '0});
    check_all('{48'h2, 48'h1, 48'h2, 48'h1, 48'h1, 48'h1, 48'h1, 48'h1});
  endtask

  task automatic s_grp2();
    select(2'h2);
    i_pmc_cpu_model.send_ev('{fetch: 1'b1, cache_hit: 1'b1, ms_ref: 1'b1, ms_wr: 1'b1, mv_ref: 1'b1, mv_wr: 1'b1,
      mb_ref: 1'b1, mem_conflict: 1'b1, vl: 7'h4, bt_cnt: 7'h5, default: '0});
    check_all('{48'h1, 48'h1, 48'h1, 48'h5, 48'h1, 48'h5, 48'ha, 48'h1});
  endtask

  // Class edges; bit 7 carries k_zero, and 175 belongs to no class
  task automatic s_grp3();
    logic [7:0] op [9] = '{8'h0f, 8'h3f, 8'h5f, 8'h6f, 8'h7b, 8'h7c, 8'hfc, 8'h7f, 8'h7d};
    select(2'h3);
    foreach (op[i]) i_pmc_cpu_model.send_ev('{issue: 1'b1, opcode: op[i][6:0], k_zero: op[i][7], default: '0});
    i_pmc_cpu_model.send_ev('{vint: 1'b1, vfp: 1'b1, vl: 7'h2, default: '0});
    check_all('{48'h1, 48'h1, 48'h1, 48'h2, 48'h2, 48'h1, 48'h2, 48'h2});
  endtask

  task automatic s_mon();
    logic [15:0] s;
    select(2'h0);
    i_pmc_cpu_model.send_ev('{issue: 1'b1, default: '0});
    read_seg(s);
    i_pmc_cpu_model.set_mode(1'b1);
    i_pmc_cpu_model.send_ev('{issue: 1'b1, fetch: 1'b1, default: '0});
    i_pmc_cpu_model.set_mode(1'b0);
    check_all('{48'h1, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0});
  endtask

  task automatic s_maint();
    select(2'h2);
    i_pmc_cpu_model.send_cmd('{minc: 1'b1, default: '0});
    i_pmc_cpu_model.send_cmd('{inj: 1'b1, default: '0});
    i_pmc_cpu_model.send_cmd('{minc: 1'b1, default: '0});
    i_pmc_cpu_model.send_cmd('{mclr: 1'b1, default: '0});
    check_all('{PMC_INJECT + 48'h1, 48'h1, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0});
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 nrst = 1'b1;
    chk({62'h0, group}, 64'h0);
    chk(rd_out.data, 64'h0);
    chk({63'h0, rd_out.valid}, 64'h0);
    s_grp0();
    s_grp1();
    s_grp2();
    s_grp3();
    s_mon();
    s_maint();
    close_out();
  end

  // About 400 cycles are needed; ten times that means a hang
  initial begin
    #40000;
    fails++;
    close_out();
  end
endmodule
